// ===== aicd_top.sv
// Six-channel limit and line-break diagnosis with an AHB-Lite slave.
// Assumes converter flags and codes arrive synchronous to i_clock.
//
// Added by the designer: register access over AHB-Lite and the address map.
module aicd_top
  import aicd_pkg::*;
#(
  parameter int NCH_P = NCH
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire aicd_ahb_req_t i_ahb,
  output aicd_ahb_rsp_t o_ahb,
  input wire logic [NCH-1:0][DW-1:0] i_code,
  input wire logic [NCH-1:0] i_adc_max,
  input wire logic [NCH-1:0] i_over,
  input wire logic [NCH-1:0] i_under,
  input wire logic [NCH-1:0] i_short_open,
  output logic [NCH-1:0][DW-1:0] o_data,
  output logic [NCH-1:0][7:0] o_diag,
  output logic [NCH-1:0] o_report,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------
  if (NCH_P != NCH) begin : g_chk
    $error("aicd_top: register layout serves six channels only");
  end

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic acc_ok; // Address phase accepted
  logic wr_pend_reg; // Write data phase this cycle
  logic [AW-1:0] wr_addr_reg; // Latched write address
  logic [31:0] rd_word; // Read mux result
  logic [31:0] hrdata_reg; // Read data for data phase
  logic [31:0] ena_reg; // Alarm enables
  logic [NCH*RW-1:0] rng_reg; // Range kind per channel
  logic [NCH-1:0] stat_reg; // Sticky report status
  logic [NCH-1:0] ien_reg; // Interrupt enables
  logic [NCH-1:0] clr_hit; // Status bits being cleared
  logic [NCH-1:0] rpt_next; // Diagnosis change this cycle
  logic [NCH-1:0][DW-1:0] lim_up_reg; // Upper limits
  logic [NCH-1:0][DW-1:0] lim_lo_reg; // Lower limits
  logic [NCH-1:0][DW-1:0] data_next; // Next channel data
  logic [NCH-1:0][7:0] diag_next; // Next diagnosis byte
  logic [NCH-1:0] lb_c; // Enabled line break present

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_nrst);

  // Write strobe for one register word
  function automatic logic wr_at(input logic [AW-1:0] a);
    return wr_pend_reg && (wr_addr_reg == a);
  endfunction

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  // Zero-wait slave, always OKAY
  assign acc_ok = i_ahb.hsel & i_ahb.htrans[HT_ACT] & i_ahb.hready;
  assign o_ahb.hreadyout = 1'b1;
  assign o_ahb.hresp = 1'b0;
  assign o_ahb.hrdata = hrdata_reg;

  // Address phase capture for writes
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
    end else begin
      wr_pend_reg <= acc_ok & i_ahb.hwrite;
      if (acc_ok) begin
        wr_addr_reg <= i_ahb.haddr[AW-1:0];
      end
    end
  end

  // Read mux, unmapped words read zero
  always_comb begin
    rd_word = '0;
    case (i_ahb.haddr[AW-1:0])
      OFS_ENA: rd_word = ena_reg;
      OFS_RNG: rd_word = 32'(rng_reg);
      OFS_STAT: rd_word = 32'(stat_reg);
      OFS_IEN: rd_word = 32'(ien_reg);
      OFS_DIAG0: rd_word = {o_diag[3], o_diag[2], o_diag[1], o_diag[0]};
      OFS_DIAG1: rd_word = {16'h0000, o_diag[5], o_diag[4]};
      default: ;
    endcase
    for (int n = 0; n < NCH; n++) begin
      if (i_ahb.haddr[AW-1:0] == OFS_LIM0 + AW'(n) * OFS_STRIDE) begin
        rd_word = {lim_up_reg[n], lim_lo_reg[n]};
      end
      if (i_ahb.haddr[AW-1:0] == OFS_DATA0 + AW'(n) * OFS_STRIDE) begin
        rd_word = 32'(o_data[n]);
      end
    end
  end

  // Read data sampled at the address phase
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      hrdata_reg <= '0;
    end else if (acc_ok && !i_ahb.hwrite) begin
      hrdata_reg <= rd_word;
    end
  end

  // ---------------------------------------------------------------
  // Configuration block
  // ---------------------------------------------------------------
  // Enable word, undefined bits dropped
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ena_reg <= ENA_DEF;
    end else if (wr_at(OFS_ENA)) begin
      ena_reg <= i_ahb.hwdata & ENA_MASK;
    end
  end

  // Range kinds, default bipolar voltage
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rng_reg <= '0;
    end else if (wr_at(OFS_RNG)) begin
      rng_reg <= i_ahb.hwdata[NCH*RW-1:0];
    end
  end

  // ---------------------------------------------------------------
  // Status and interrupt
  // ---------------------------------------------------------------
  assign clr_hit = wr_at(OFS_CLR) ? i_ahb.hwdata[NCH-1:0] : '0;

  // Sticky bits, a new report wins over a clear
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~clr_hit) | rpt_next;
    end
  end

  // Interrupt enables
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      ien_reg <= '0;
    end else if (wr_at(OFS_IEN)) begin
      ien_reg <= i_ahb.hwdata[NCH-1:0];
    end
  end

  // Level interrupt from enabled sticky bits
  assign o_irq = |(stat_reg & ien_reg);

  // ---------------------------------------------------------------
  // Per-channel diagnosis
  // ---------------------------------------------------------------
  for (genvar n = 0; n < NCH; n++) begin : g_ch
    logic up_en; // Upper alarm enable
    logic lo_en; // Lower alarm enable
    logic lb_en; // Line-break alarm enable
    logic is_cur; // Current range
    logic is_bip; // Bipolar voltage range
    logic above; // Code above upper limit
    logic below; // Code below lower limit
    logic [AW-1:0] lim_ofs; // This channel's limit word

    assign lim_ofs = OFS_LIM0 + AW'(n) * OFS_STRIDE;
    assign up_en = ena_reg[ENA_UP_LSB+n];
    assign lo_en = ena_reg[ENA_LO_LSB+n];
    assign lb_en = ena_reg[ENA_LB_LSB+n];
    assign is_cur = rng_reg[n*RW+:RW] == RNG_CUR;
    assign is_bip = rng_reg[n*RW+:RW] == RNG_VBIP;
    // Unsigned compares; overlapping window is the user's fault
    assign above = i_code[n] > lim_up_reg[n];
    assign below = i_code[n] < lim_lo_reg[n];
    // Converter pinned at maximum means open line
    assign lb_c[n] = lb_en & i_adc_max[n];

    // Limit word: upper high half, lower low half, clamped
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        lim_up_reg[n] <= UP_DEF;
        lim_lo_reg[n] <= LO_DEF;
      end else if (wr_at(lim_ofs)) begin
        lim_up_reg[n] <= (i_ahb.hwdata[2*DW-1:DW] < UP_MIN) ?
          UP_MIN : i_ahb.hwdata[2*DW-1:DW];
        lim_lo_reg[n] <= (i_ahb.hwdata[DW-1:0] > LO_MAX) ?
          LO_MAX : i_ahb.hwdata[DW-1:0];
      end
    end

    // Priority: break, over/under range, limits
    always_comb begin
      diag_next[n] = DG_NORMAL;
      data_next[n] = i_code[n];
      if (lb_c[n]) begin
        diag_next[n] = DG_BREAK;
        if (is_cur) begin
          // Link open: full scale, field lines: zero
          data_next[n] = i_short_open[n] ? CODE_FULL : CODE_ZERO;
        end else begin
          // Voltage ranges by polarity
          data_next[n] = is_bip ? CODE_BIP : CODE_FULL;
        end
      end else if (i_over[n]) begin
        diag_next[n] = DG_OVER;
      end else if (i_under[n]) begin
        diag_next[n] = DG_UNDER;
      end else if (up_en && above) begin
        diag_next[n] = DG_UPPER;
      end else if (lo_en && below) begin
        diag_next[n] = DG_LOWER;
      end
    end

    // Report only when the byte changes
    assign rpt_next[n] = diag_next[n] != o_diag[n];

    // Output registers
    always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
        o_diag[n] <= DG_NORMAL;
        o_data[n] <= CODE_ZERO;
        o_report[n] <= 1'b0;
      end else begin
        o_diag[n] <= diag_next[n];
        o_data[n] <= data_next[n];
        o_report[n] <= rpt_next[n];
      end
    end

    // -------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------
    sequence s_quiet;
      !lb_c[n] && !i_over[n] && !i_under[n];
    endsequence

    sequence s_break_held;
      lb_c[n] [*2];
    endsequence

    property p_upper;
      s_quiet and (up_en && above) |=> o_diag[n] == DG_UPPER;
    endproperty
    a_upper: assert property (p_upper)
      else $error("upper limit code missing");

    property p_lower;
      s_quiet and (!(up_en && above) && lo_en && below)
        |=> o_diag[n] == DG_LOWER;
    endproperty
    a_lower: assert property (p_lower)
      else $error("lower limit code missing");

    property p_true_data;
      (o_diag[n] == DG_UPPER || o_diag[n] == DG_LOWER)
        |-> o_data[n] == $past(i_code[n]);
    endproperty
    a_true_data: assert property (p_true_data)
      else $error("limit alarm altered data");

    property p_normal;
      s_quiet and !(up_en && above) && !(lo_en && below)
        |=> o_diag[n] == DG_NORMAL;
    endproperty
    a_normal: assert property (p_normal)
      else $error("normal code missing");

    property p_once;
      s_break_held |=> !o_report[n];
    endproperty
    a_once: assert property (p_once)
      else $error("repeated report while fault held");

    property p_rpt_cause;
      o_report[n] |-> o_diag[n] != $past(o_diag[n]) && stat_reg[n];
    endproperty
    a_rpt_cause: assert property (p_rpt_cause)
      else $error("report without change or status");

    property p_lb_link;
      lb_c[n] && is_cur && i_short_open[n]
        |=> o_diag[n] == DG_BREAK && o_data[n] == CODE_FULL;
    endproperty
    a_lb_link: assert property (p_lb_link)
      else $error("open link not full scale");

    property p_lb_field;
      lb_c[n] && is_cur && !i_short_open[n]
        |=> o_diag[n] == DG_BREAK && o_data[n] == CODE_ZERO;
    endproperty
    a_lb_field: assert property (p_lb_field)
      else $error("open field line not zero");

    property p_lb_volt;
      lb_c[n] && !is_cur
        |=> o_data[n] == (is_bip ? CODE_BIP : CODE_FULL);
    endproperty
    a_lb_volt: assert property (p_lb_volt)
      else $error("voltage break data wrong");

    property p_lb_off;
      !lb_en |=> o_diag[n] != DG_BREAK;
    endproperty
    a_lb_off: assert property (p_lb_off)
      else $error("break reported while disabled");

    property p_over_first;
      !lb_c[n] && i_over[n] |=> o_diag[n] == DG_OVER;
    endproperty
    a_over_first: assert property (p_over_first)
      else $error("over range not preferred");

    property p_lim_range;
      lim_up_reg[n] >= UP_MIN && lim_lo_reg[n] <= LO_MAX;
    endproperty
    a_lim_range: assert property (p_lim_range)
      else $error("limit outside legal range");

    // Every report leaves its mark in the sticky status
    property p_stat_set;
      rpt_next[n] |=> stat_reg[n];
    endproperty
    a_stat_set: assert property (p_stat_set)
      else $error("report not kept in status");

    // No pulse while the diagnosis byte stays put
    property p_no_repeat;
      diag_next[n] == o_diag[n] |=> !o_report[n];
    endproperty
    a_no_repeat: assert property (p_no_repeat)
      else $error("report without a change");

    // Without a line break the measured code passes untouched
    property p_true_pass;
      !lb_c[n] |=> o_data[n] == $past(i_code[n]);
    endproperty
    a_true_pass: assert property (p_true_pass)
      else $error("data substituted without break");
  end

  // Set beats clear on the sticky status
  property p_set_wins;
    (rpt_next[0] && clr_hit[0]) |=> stat_reg[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("status event lost to clear");

  // A clear with no new report empties the status bit
  property p_clr_drops;
    (clr_hit[0] && !rpt_next[0]) |=> !stat_reg[0];
  endproperty
  a_clr_drops: assert property (p_clr_drops)
    else $error("status bit not cleared");

endmodule

// ===== aicd_pkg.sv
// Shared constants and carriers for the analog input channel diagnosis.
// Assumes a single 50 MHz clock and an AHB-Lite master on the bus side.
package aicd_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int NCH = 6; // Channel count
  localparam int DW = 16; // Measured code width
  localparam int AW = 8; // Decoded address bits
  localparam int RW = 2; // Range select field width
  localparam int HT_ACT = 1; // htrans bit set for NONSEQ and SEQ

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [AW-1:0] OFS_ENA = 8'h00; // Alarm enables
  localparam logic [AW-1:0] OFS_LIM0 = 8'h04; // Channel 0 limits
  localparam logic [AW-1:0] OFS_STRIDE = 8'h04; // Word stride
  localparam logic [AW-1:0] OFS_RNG = 8'h1C; // Range selects
  localparam logic [AW-1:0] OFS_RSV = 8'h20; // Spare word of block
  localparam logic [AW-1:0] OFS_STAT = 8'h24; // Sticky report status
  localparam logic [AW-1:0] OFS_CLR = 8'h28; // Status clear
  localparam logic [AW-1:0] OFS_IEN = 8'h2C; // Interrupt enable
  localparam logic [AW-1:0] OFS_DIAG0 = 8'h30; // Diag bytes 0..3
  localparam logic [AW-1:0] OFS_DIAG1 = 8'h34; // Diag bytes 4..5
  localparam logic [AW-1:0] OFS_DATA0 = 8'h40; // Channel 0 data

  // ---------------------------------------------------------------
  // Field layout and reset values
  // ---------------------------------------------------------------
  localparam int ENA_UP_LSB = 0; // Upper enable, bit n of channel n
  localparam int ENA_LO_LSB = 8; // Lower enable
  localparam int ENA_LB_LSB = 16; // Line-break enable
  localparam logic [31:0] ENA_MASK = 32'h003F3F3F;
  localparam logic [31:0] ENA_DEF = 32'h00000000;
  localparam logic [DW-1:0] UP_DEF = 16'h7FFF; // 32767
  localparam logic [DW-1:0] LO_DEF = 16'h0000;
  localparam logic [DW-1:0] UP_MIN = 16'h0001;
  localparam logic [DW-1:0] LO_MAX = 16'hFFFE;
  localparam logic [DW-1:0] CODE_FULL = 16'hFFFF; // 65535
  localparam logic [DW-1:0] CODE_BIP = 16'h7FFF; // 32767
  localparam logic [DW-1:0] CODE_ZERO = 16'h0000;

  // ---------------------------------------------------------------
  // Range kinds and diagnosis codes
  // ---------------------------------------------------------------
  localparam logic [RW-1:0] RNG_VBIP = 2'h0; // Bipolar voltage
  localparam logic [RW-1:0] RNG_VUNI = 2'h1; // Unipolar voltage
  localparam logic [RW-1:0] RNG_CUR = 2'h2; // Current
  localparam logic [7:0] DG_NORMAL = 8'hA0;
  localparam logic [7:0] DG_UNDER = 8'hA2;
  localparam logic [7:0] DG_OVER = 8'hA3;
  localparam logic [7:0] DG_BREAK = 8'hA6;
  localparam logic [7:0] DG_UPPER = 8'hA7;
  localparam logic [7:0] DG_LOWER = 8'hA8;

  // ---------------------------------------------------------------
  // Bus carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic hready;
    logic [31:0] hwdata;
  } aicd_ahb_req_t;

  typedef struct packed {
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } aicd_ahb_rsp_t;

endpackage

// ===== aicd_ctrl_model.sv
// Controller-side AHB-Lite master model for the channel diagnosis block.
// Assumes one slave whose hreadyout is the bus hready; whole words only.
module aicd_ctrl_model
  import aicd_pkg::*;
(
  input wire logic i_clock,
  input wire aicd_ahb_rsp_t i_ahb,
  output aicd_ahb_req_t o_ahb
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Bus state
  // ---------------------------------------------------------------
  logic sel = 1'b0; // Slave select
  logic [31:0] addr = 32'h00000000; // Address phase
  logic [1:0] trans = 2'h0; // IDLE or NONSEQ
  logic wr = 1'b0; // Direction
  logic [31:0] wdata = 32'h00000000; // Data phase

  // Request carrier, hready fed back from the slave
  assign o_ahb = '{hsel: sel, haddr: addr, htrans: trans, hwrite: wr,
    hsize: 3'h2, hready: i_ahb.hreadyout, hwdata: wdata};

  // ---------------------------------------------------------------
  // One single transfer, waits on hready in both phases
  // ---------------------------------------------------------------
  task automatic xfer(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    sel <= 1'b1;
    addr <= a;
    trans <= 2'h2;
    wr <= w;
    do @(posedge i_clock); while (i_ahb.hreadyout !== 1'b1);
    trans <= 2'h0;
    addr <= ~a; // Released address shows no stale value
    if (w) begin
      wdata <= d;
    end
    do @(posedge i_clock); while (i_ahb.hreadyout !== 1'b1);
    q = i_ahb.hrdata;
    wdata <= ~wdata; // Released data toggles
  endtask

  // Full parameter download, nine words from offset zero
  task automatic download(input logic [31:0] blk [9]);
    logic [31:0] q;
    for (int i = 0; i < 9; i++) begin
      xfer(1'b1, 32'(i * 4), blk[i], q);
    end
  endtask
endmodule

// ===== analog_input_channel_diagnosis_tb.sv
// Self-checking bench for the six-channel limit and line-break diagnosis.
// Assumes the controller model drives the bus; the bench drives converters.
module analog_input_channel_diagnosis_tb
  import aicd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic i_clock = 1'b0; // 50 MHz
  logic i_nrst = 1'b0; // Reset held at start
  aicd_ahb_req_t ahb_req; // Bus request
  aicd_ahb_rsp_t ahb_rsp; // Bus response
  logic [NCH-1:0][DW-1:0] code = {NCH{16'h4000}}; // Measured codes
  logic [NCH-1:0] amax = '0; // Converter at maximum
  logic [NCH-1:0] over = '0; // Over range flags
  logic [NCH-1:0] under = '0; // Under range flags
  logic [NCH-1:0] sopen = '0; // Shorting link open
  logic [NCH-1:0][DW-1:0] o_data; // Channel data
  logic [NCH-1:0][7:0] o_diag; // Diagnosis bytes
  logic [NCH-1:0] o_report; // Report pulses
  logic o_irq; // Interrupt level
  int mismatches = 0; // Failed comparisons
  int check_count = 0; // All comparisons
  // Parameter block: ch0 limits on, line break on ch0..ch3
  logic [31:0] blk [9] = '{32'h000F0101, 32'h90001000, 32'h20001000,
    32'h7FFF0000, 32'h7FFF0000, 32'h7FFF0000, 32'h7FFF0000,
    32'h0000001A, 32'h00000000};

  // ---------------------------------------------------------------
  // Instances
  // ---------------------------------------------------------------
  aicd_top #(.NCH_P(NCH)) u_aicd_top (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_ahb(ahb_req), .o_ahb(ahb_rsp), .i_code(code), .i_adc_max(amax),
    .i_over(over), .i_under(under), .i_short_open(sopen), .o_data(o_data),
    .o_diag(o_diag), .o_report(o_report), .o_irq(o_irq));
  aicd_ctrl_model u_aicd_ctrl_model (.i_clock(i_clock), .i_ahb(ahb_rsp),
    .o_ahb(ahb_req));

  // Clock generator
  initial begin
    forever #10 i_clock = ~i_clock;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // Compare and count
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register write
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_aicd_ctrl_model.xfer(1'b1, a, d, q);
  endtask

  // Register read with expectation
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] q;
    u_aicd_ctrl_model.xfer(1'b0, a, 32'h00000000, q);
    cmp(q, exp);
    cmp(32'(ahb_rsp.hresp), 32'h0);
  endtask

  // Drive one channel, check result, pulse and persistence
  // Flags f: adc max, over, shorting link open, under
  task automatic step(input int ch, input logic [15:0] c,
      input logic [3:0] f, input logic [7:0] ed, input logic [15:0] ev,
      input logic er);
    @(posedge i_clock);
    code[ch] <= c;
    amax[ch] <= f[3];
    over[ch] <= f[2];
    sopen[ch] <= f[1];
    under[ch] <= f[0];
    @(posedge i_clock);
    #1;
    cmp(32'(o_diag[ch]), 32'(ed));
    cmp(32'(o_data[ch]), 32'(ev));
    cmp(32'(o_report[ch]), 32'(er));
    @(posedge i_clock);
    #1;
    cmp(32'(o_report[ch]), 32'h0);
    cmp(32'(o_diag[ch]), 32'(ed));
  endtask

  // Counts, verdict, end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial begin
    #100000;
    mismatches++;
    wrap_up();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    // Reset values
    rd({24'h0, OFS_ENA}, ENA_DEF);
    for (int n = 0; n < NCH; n++) begin
      rd(32'(OFS_LIM0) + 32'(4 * n), {UP_DEF, LO_DEF});
      #1;
      cmp(32'(o_diag[n]), 32'(DG_NORMAL));
    end
    $display("test reset done");
    // Download and read back the whole block
    u_aicd_ctrl_model.download(blk);
    for (int i = 0; i < 9; i++) begin
      rd(32'(i * 4), blk[i]);
    end
    $display("test download done");
    // Interrupt: mask, raise, enable, clear
    wr({24'h0, OFS_CLR}, 32'h0000003F);
    rd({24'h0, OFS_STAT}, 32'h00000000);
    wr({24'h0, OFS_IEN}, 32'h00000002);
    step(0, 16'h9001, 4'h0, DG_UPPER, 16'h9001, 1'b1);
    cmp(32'(o_irq), 32'h0);
    rd({24'h0, OFS_STAT}, 32'h00000001);
    rd({24'h0, OFS_DIAG0}, 32'hA0A0A0A7);
    rd({24'h0, OFS_DATA0}, 32'h00009001);
    wr({24'h0, OFS_IEN}, 32'h00000001);
    #1;
    cmp(32'(o_irq), 32'h1);
    wr({24'h0, OFS_CLR}, 32'h00000001);
    #1;
    cmp(32'(o_irq), 32'h0);
    rd({24'h0, OFS_STAT}, 32'h00000000);
    // Clear lands in the cycle of a new report: the report keeps its bit
    fork
      wr({24'h0, OFS_CLR}, 32'h00000001);
      begin
        repeat (2) @(posedge i_clock);
        code[0] <= 16'h0FFF;
      end
    join
    rd({24'h0, OFS_STAT}, 32'h00000001);
    rd({24'h0, OFS_DIAG0}, 32'hA0A0A0A8);
    $display("test interrupt done");
    // Limits, ranges, line break and priority
    step(0, 16'h9000, 4'h0, DG_NORMAL, 16'h9000, 1'b1);
    step(0, 16'h0FFF, 4'h0, DG_LOWER, 16'h0FFF, 1'b1);
    step(0, 16'h1000, 4'h0, DG_NORMAL, 16'h1000, 1'b1);
    step(1, 16'hF000, 4'h0, DG_NORMAL, 16'hF000, 1'b0);
    step(1, 16'h0100, 4'h1, DG_UNDER, 16'h0100, 1'b1);
    step(1, 16'h4000, 4'h0, DG_NORMAL, 16'h4000, 1'b1);
    step(0, 16'hA000, 4'h4, DG_OVER, 16'hA000, 1'b1);
    step(0, 16'hA000, 4'hE, DG_BREAK, CODE_FULL, 1'b1);
    step(0, 16'hA000, 4'hC, DG_BREAK, CODE_ZERO, 1'b0);
    step(0, 16'h4000, 4'h0, DG_NORMAL, 16'h4000, 1'b1);
    step(2, 16'h4000, 4'h8, DG_BREAK, CODE_FULL, 1'b1);
    step(3, 16'h4000, 4'h8, DG_BREAK, CODE_BIP, 1'b1);
    step(4, 16'h4000, 4'h8, DG_NORMAL, 16'h4000, 1'b0);
    step(2, 16'h4000, 4'h0, DG_NORMAL, 16'h4000, 1'b1);
    step(3, 16'h4000, 4'h0, DG_NORMAL, 16'h4000, 1'b1);
    $display("test diagnosis done");
    // Limit clamping and unmapped space
    wr(32'(OFS_LIM0) + 32'h4, 32'h0000FFFF);
    rd(32'(OFS_LIM0) + 32'h4, {UP_MIN, LO_MAX});
    rd(32'h000000FC, 32'h00000000);
    $display("test clamp done");
    wrap_up();
  end
endmodule
